/* rtl/tws_fifo.v */
// Small flip-flop FIFO with valid/ready handshakes on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module tws_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // Clock and reset
    input wire clk_in,
    input wire srst_in,
    // Fill side
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    // Drain side
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;
    integer i;

    assign in_ready_out = (count_reg != DEPTH[AW:0]);
    assign out_valid_out = (count_reg != {(AW+1){1'b0}});
    assign out_data_out = mem_reg[rd_ptr_reg];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1)
                mem_reg[i] <= {WIDTH{1'b0}};
        end
        else
        begin
            if (push)
            begin
                mem_reg[wr_ptr_reg] <= in_data_in;
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            if (push && !pop)
                count_reg <= count_reg + 1'b1;
            else if (pop && !push)
                count_reg <= count_reg - 1'b1;
        end
    end
endmodule // tws_fifo

`default_nettype wire

/* rtl/tws_master.v */
// Software handshake and master transmitter of the two-wire serial unit.
// Assumes synchronous inputs on clk_in and an external wired-AND bus.
//
// Contract
// - Interrupt request only when done flag, interface enable and global enable all set.
// - Done flag sets after every START, address packet and data packet the unit performs.
// - While done flag set, status shows bus state; unit waits for software.
// - Control write with one in done position clears flag; zero leaves it.
// - No bus operation while flag set; start selected operation once cleared.
// - After START, set flag and load start-sent status.
// - After address packet, set flag, status reports slave acknowledge.
// - After data packet, set flag, status reports receiver acknowledge.
// - One data register supplies both address-with-direction and data bytes.
// - No done flag or interrupt after a STOP.
// - Serial clock held low while done flag set.
// - Address packet is seven bits MSB first, direction, then acknowledge.
// - Receiver acknowledges by pulling data low on ninth clock.
`timescale 1ns/1ps
`default_nettype none
`include "tws_regs.vh"

module tws_master (
    // Clock and reset
    input wire clk_in,
    input wire srst_in,
    // Control register write
    input wire ctl_wr_in,
    input wire [7:0] ctl_wdata_in,
    input wire global_ie_in,
    // Data register writes through the FIFO
    input wire data_valid_in,
    output wire data_ready_out,
    input wire [7:0] data_in,
    // Status
    output reg done_flag_out,
    output reg interface_ie_out,
    output reg [7:0] bus_state_out,
    output wire irq_out,
    output reg busy_out,
    // Two-wire pins, enable low means driving low
    input wire scl_in,
    output wire scl_out,
    output wire scl_oe_n_out,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe_n_out
);
    // ************************************************
    // Operation sequencer states
    // ************************************************
    localparam ST_IDLE = 3'h0;
    localparam ST_START = 3'h1;
    localparam ST_BIT = 3'h2;
    localparam ST_ACK = 3'h3;
    localparam ST_STOP = 3'h4;
    localparam ST_WAIT = 3'h5;
    localparam integer QCYC_FULL = `TWS_QUARTER_CYC;
    localparam [15:0] QCYC = QCYC_FULL[15:0];

    reg [2:0] state_reg;
    reg [15:0] tick_reg;
    reg [1:0] phase_reg;
    reg [3:0] bit_reg;
    reg [7:0] shift_reg;
    reg first_pkt_reg;
    reg scl_low_reg;
    reg sda_low_reg;
    reg done_next;
    wire fifo_valid;
    wire [7:0] fifo_data;
    wire fifo_pop;
    wire q_tick;
    wire clr_done;
    wire go_start;
    wire go_stop;
    wire go_byte;
    wire set_done;
    wire scl_stretch;

    // ************************************************
    // Shared address/data buffer
    // ************************************************
    tws_fifo #(
        .WIDTH(`TWS_FIFO_WIDTH),
        .DEPTH(`TWS_FIFO_DEPTH),
        .AW(2)
    ) u_fifo (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .in_valid_in(data_valid_in),
        .in_ready_out(data_ready_out),
        .in_data_in(data_in),
        .out_valid_out(fifo_valid),
        .out_ready_in(fifo_pop),
        .out_data_out(fifo_data)
    );

    // Slave holding the released clock low freezes the bit timer
    assign scl_stretch = scl_oe_n_out && !scl_in;
    assign q_tick = (tick_reg == QCYC - 16'h0001) && !scl_stretch;
    assign set_done = q_tick && (phase_reg == 2'h3)
        && ((state_reg == ST_START) || (state_reg == ST_ACK));
    assign clr_done = ctl_wr_in && ctl_wdata_in[`TWS_CTL_DONE_BIT];
    // Operations launch only from idle with the flag cleared
    assign go_start = clr_done && ctl_wdata_in[`TWS_CTL_START_BIT];
    assign go_stop = clr_done && ctl_wdata_in[`TWS_CTL_STOP_BIT]
        && !ctl_wdata_in[`TWS_CTL_START_BIT];
    // Byte waits in ST_WAIT until the buffer has a word; stalls the drain side
    assign go_byte = clr_done && !ctl_wdata_in[`TWS_CTL_START_BIT]
        && !ctl_wdata_in[`TWS_CTL_STOP_BIT];
    assign fifo_pop = (state_reg == ST_WAIT) && fifo_valid;
    assign irq_out = done_flag_out && interface_ie_out && global_ie_in;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_n_out = !(scl_low_reg || done_flag_out);
    assign sda_oe_n_out = !sda_low_reg;

    // Set wins over a clear in the same cycle
    always @*
    begin
        done_next = done_flag_out;
        if (clr_done)
            done_next = 1'b0;
        if (set_done)
            done_next = 1'b1;
    end

    // ************************************************
    // Sequencer
    // ************************************************
    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            state_reg <= ST_IDLE;
            tick_reg <= 16'h0000;
            phase_reg <= 2'h0;
            bit_reg <= 4'h0;
            shift_reg <= 8'h00;
            first_pkt_reg <= 1'b0;
            scl_low_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            done_flag_out <= 1'b0;
            interface_ie_out <= 1'b0;
            bus_state_out <= `TWS_ST_IDLE;
            busy_out <= 1'b0;
        end
        else
        begin
            if (ctl_wr_in)
                interface_ie_out <= ctl_wdata_in[`TWS_CTL_IE_BIT];
            if (q_tick)
                tick_reg <= 16'h0000;
            else if (!scl_stretch)
                tick_reg <= tick_reg + 16'h0001;
            case (state_reg)
                ST_IDLE:
                begin
                    tick_reg <= 16'h0000;
                    phase_reg <= 2'h0;
                    if (done_flag_out && go_start)
                    begin
                        state_reg <= ST_START;
                        busy_out <= 1'b1;
                    end
                    else if (done_flag_out && go_stop)
                        state_reg <= ST_STOP;
                    else if (done_flag_out && go_byte)
                        state_reg <= ST_WAIT;
                    else if (!done_flag_out && go_start)
                    begin
                        state_reg <= ST_START;
                        busy_out <= 1'b1;
                    end
                end
                ST_WAIT:
                begin
                    tick_reg <= 16'h0000;
                    if (fifo_valid)
                    begin
                        shift_reg <= fifo_data;
                        bit_reg <= 4'h0;
                        phase_reg <= 2'h0;
                        state_reg <= ST_BIT;
                    end
                end
                ST_START:
                    if (q_tick)
                    begin
                        phase_reg <= phase_reg + 2'h1;
                        case (phase_reg)
                            2'h0: scl_low_reg <= 1'b0;
                            2'h1: sda_low_reg <= 1'b1;
                            2'h2: scl_low_reg <= 1'b1;
                            default:
                            begin
                                first_pkt_reg <= 1'b1;
                                bus_state_out <= `TWS_ST_START_OK;
                                state_reg <= ST_IDLE;
                            end
                        endcase
                    end
                ST_BIT:
                    if (q_tick)
                    begin
                        phase_reg <= phase_reg + 2'h1;
                        case (phase_reg)
                            // MSB first, address then direction bit
                            2'h0: sda_low_reg <= !shift_reg[7];
                            2'h1: scl_low_reg <= 1'b0;
                            2'h2: scl_low_reg <= 1'b1;
                            default:
                            begin
                                shift_reg <= {shift_reg[6:0], 1'b0};
                                bit_reg <= bit_reg + 4'h1;
                                if (bit_reg == 4'h7)
                                    state_reg <= ST_ACK;
                            end
                        endcase
                    end
                ST_ACK:
                    if (q_tick)
                    begin
                        phase_reg <= phase_reg + 2'h1;
                        case (phase_reg)
                            2'h0: sda_low_reg <= 1'b0;
                            2'h1: scl_low_reg <= 1'b0;
                            2'h2: shift_reg[0] <= sda_in;
                            default:
                            begin
                                scl_low_reg <= 1'b1;
                                first_pkt_reg <= 1'b0;
                                if (first_pkt_reg)
                                    bus_state_out <= shift_reg[0] ? `TWS_ST_ADDR_NACK
                                        : `TWS_ST_ADDR_ACK;
                                else
                                    bus_state_out <= shift_reg[0] ? `TWS_ST_DATA_NACK
                                        : `TWS_ST_DATA_ACK;
                                state_reg <= ST_IDLE;
                            end
                        endcase
                    end
                ST_STOP:
                    if (q_tick)
                    begin
                        phase_reg <= phase_reg + 2'h1;
                        case (phase_reg)
                            2'h0: sda_low_reg <= 1'b1;
                            2'h1: scl_low_reg <= 1'b0;
                            2'h2: sda_low_reg <= 1'b0;
                            default:
                            begin
                                // No flag after a stop; bus returns idle
                                bus_state_out <= `TWS_ST_IDLE;
                                busy_out <= 1'b0;
                                state_reg <= ST_IDLE;
                            end
                        endcase
                    end
                default:
                    state_reg <= ST_IDLE;
            endcase
            // Status only changes with a completed event, so stays stable under flag
            done_flag_out <= done_next;
        end
    end
endmodule // tws_master

`default_nettype wire

/* rtl/tws_regs.vh */
// Constants for the two-wire serial unit: control fields, status codes, timing.
// Assumes a 200 MHz system clock; included by the design files by bare name.
`ifndef TWS_REGS_VH
`define TWS_REGS_VH

// Control write fields
`define TWS_CTL_DONE_BIT 7
`define TWS_CTL_START_BIT 5
`define TWS_CTL_STOP_BIT 4
`define TWS_CTL_IE_BIT 0

// Status codes
`define TWS_ST_IDLE 8'hF8
`define TWS_ST_START_OK 8'h08
`define TWS_ST_ADDR_ACK 8'h18
`define TWS_ST_ADDR_NACK 8'h20
`define TWS_ST_DATA_ACK 8'h28
`define TWS_ST_DATA_NACK 8'h30

// Timing: quarter of the serial bit time
`define TWS_CLK_MHZ 200
`define TWS_QUARTER_NS 1250
`define TWS_QUARTER_CYC ((`TWS_QUARTER_NS * `TWS_CLK_MHZ) / 1000)

`define TWS_FIFO_WIDTH 8
`define TWS_FIFO_DEPTH 4

`endif

/* testbench/tb_tws_master.sv */
// Self-checking bench for the two-wire master: control writes, FIFO pushes, slave model.
// Assumes tws_regs.vh on the include path; pull-ups on both lines.
`timescale 1ns/1ps
`default_nettype none
`include "tws_regs.vh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_tws_master;
    logic clk_in = 0, srst_in = 1, ctl_wr_in = 0, global_ie_in = 0, data_valid_in = 0;
    logic nack_data = 0;
    logic [7:0] ctl_wdata_in = 8'h00, data_in = 8'h00;
    logic [7:0] bytes [4] = '{8'hA4, 8'h5A, 8'hC3, 8'h81};
    logic [7:0] codes [4] = '{`TWS_ST_ADDR_ACK, `TWS_ST_DATA_ACK, `TWS_ST_DATA_ACK,
        `TWS_ST_DATA_NACK};
    wire data_ready_out, done_flag_out, interface_ie_out, irq_out, busy_out;
    wire scl_out, scl_oe_n_out, sda_out, sda_oe_n_out, slave_oe_n;
    wire [7:0] bus_state_out, last_byte;
    wire scl_line = scl_oe_n_out ? 1'b1 : 1'b0;
    wire sda_line = (sda_oe_n_out && slave_oe_n) ? 1'b1 : 1'b0;
    int fail_count = 0, total_checks = 0;
    always #2.5 clk_in = ~clk_in;
    tws_master i_dut (.clk_in(clk_in), .srst_in(srst_in), .ctl_wr_in(ctl_wr_in),
        .ctl_wdata_in(ctl_wdata_in), .global_ie_in(global_ie_in), .data_valid_in(data_valid_in),
        .data_ready_out(data_ready_out), .data_in(data_in), .done_flag_out(done_flag_out),
        .interface_ie_out(interface_ie_out), .bus_state_out(bus_state_out), .irq_out(irq_out),
        .busy_out(busy_out), .scl_in(scl_line), .scl_out(scl_out), .scl_oe_n_out(scl_oe_n_out),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out));
    tws_slave_model i_slave (.scl_in(scl_line), .sda_in(sda_line), .nack_data_in(nack_data),
        .sda_oe_n_out(slave_oe_n), .last_byte_out(last_byte));
    task automatic ctl_write(input logic [7:0] v);
        @(posedge clk_in);
        #1 ctl_wr_in = 1;
        ctl_wdata_in = v;
        @(posedge clk_in);
        #1 ctl_wr_in = 0;
    endtask
    task automatic push(input logic [7:0] b);
        int n = 0;
        @(posedge clk_in);
        #1 data_valid_in = 1;
        data_in = b;
        while (data_ready_out !== 1'b1 && n < 100)
        begin
            @(posedge clk_in);
            #1 n++;
        end
        @(posedge clk_in);
        #1 data_valid_in = 0;
    endtask
    // Polls the flag, as software does with interrupts off
    task automatic wait_done();
        int n = 0;
        while (done_flag_out !== 1'b1 && n < 12000)
        begin
            @(posedge clk_in);
            #1 n++;
        end
    endtask
    task give_verdict;
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        int n;
        repeat (6) @(posedge clk_in);
        #1 srst_in = 0;
        `CHK({done_flag_out, interface_ie_out, busy_out, scl_oe_n_out, sda_oe_n_out}, 5'h03)
        `CHK(bus_state_out, `TWS_ST_IDLE)
        `CHK({scl_out, sda_out}, 2'b00)
        ctl_write(8'h01);
        `CHK({done_flag_out, interface_ie_out}, 2'b01)
        ctl_write(8'hA1);
        wait_done();
        `CHK(bus_state_out, `TWS_ST_START_OK)
        `CHK(irq_out, 1'b0)
        global_ie_in = 1;
        @(posedge clk_in);
        #1 `CHK(irq_out, 1'b1)
        // Registers loaded before the flag is cleared
        for (int i = 0; i < 4; i++)
            push(bytes[i]);
        `CHK(data_ready_out, 1'b0)
        // Start bit without the clear bit must not launch anything
        ctl_write(8'h21);
        repeat (200) @(posedge clk_in);
        #1;
        `CHK({done_flag_out, scl_oe_n_out, bus_state_out}, {2'b10, `TWS_ST_START_OK})
        for (int i = 0; i < 4; i++)
        begin
            nack_data = (i == 3);
            ctl_write(8'h81);
            wait_done();
            `CHK(last_byte, bytes[i])
            `CHK(bus_state_out, codes[i])
        end
        `CHK(data_ready_out, 1'b1)
        ctl_write(8'hA1);
        wait_done();
        `CHK(bus_state_out, `TWS_ST_START_OK)
        push(8'h61);
        ctl_write(8'h81);
        wait_done();
        `CHK(bus_state_out, `TWS_ST_ADDR_NACK)
        // Enable off: flag stays, request drops
        ctl_write(8'h00);
        `CHK({done_flag_out, irq_out}, 2'b10)
        ctl_write(8'h91);
        n = 0;
        while (busy_out !== 1'b0 && n < 3000)
        begin
            @(posedge clk_in);
            #1 n++;
        end
        `CHK({done_flag_out, busy_out, irq_out, bus_state_out}, {3'b000, `TWS_ST_IDLE})
        give_verdict();
    end
    initial
    begin
        #400000;
        fail_count++;
        give_verdict();
    end
endmodule // tb_tws_master
bind tws_master tws_master_props i_props (.clk_in(clk_in), .srst_in(srst_in),
    .ctl_wr_in(ctl_wr_in), .ctl_wdata_in(ctl_wdata_in), .global_ie_in(global_ie_in),
    .done_flag_out(done_flag_out), .interface_ie_out(interface_ie_out),
    .bus_state_out(bus_state_out), .irq_out(irq_out), .busy_out(busy_out),
    .scl_oe_n_out(scl_oe_n_out), .sda_oe_n_out(sda_oe_n_out));
`default_nettype wire

/* testbench/tws_master_props.sv */
// Checker for the two-wire serial unit master, watching its top-level ports only.
// Assumes one clock domain and the status codes of tws_regs.vh.
`timescale 1ns/1ps
`default_nettype none
module tws_master_props (
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Software side
    input wire logic ctl_wr_in,
    input wire logic [7:0] ctl_wdata_in,
    input wire logic global_ie_in,
    input wire logic done_flag_out,
    input wire logic interface_ie_out,
    input wire logic [7:0] bus_state_out,
    input wire logic irq_out,
    input wire logic busy_out,
    // Pin enables
    input wire logic scl_oe_n_out,
    input wire logic sda_oe_n_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    logic done_prev_reg;
    logic [10:0] start_age_reg;
    wire logic clr_wr = ctl_wr_in && ctl_wdata_in[7];
    wire logic held = done_flag_out && done_prev_reg;
    wire logic start_go = clr_wr && ctl_wdata_in[5] && !busy_out && !done_flag_out;
    // Cycles since a start from idle; too long a span for a delay range
    always @(posedge clk_in)
    begin
        done_prev_reg <= done_flag_out;
        if (srst_in || done_flag_out)
            start_age_reg <= 11'h000;
        else if (start_go)
            start_age_reg <= 11'h001;
        else if (start_age_reg != 11'h000 && start_age_reg != 11'h7FF)
            start_age_reg <= start_age_reg + 11'h001;
    end
    a_irq_gating: assert property (
        irq_out == (done_flag_out && interface_ie_out && global_ie_in))
        else $error("interrupt request does not follow flag and enables");
    a_status_code: assert property ($rose(done_flag_out) |->
        bus_state_out inside {8'h08, 8'h18, 8'h20, 8'h28, 8'h30})
        else $error("flag raised without a bus status code");
    a_clear_on_one: assert property (clr_wr && done_flag_out |=> !done_flag_out)
        else $error("flag not cleared by a one");
    a_keep_on_zero: assert property (
        ctl_wr_in && !ctl_wdata_in[7] && done_flag_out |=> done_flag_out)
        else $error("flag lost on a zero write");
    a_sda_quiet: assert property (held |-> $stable(sda_oe_n_out))
        else $error("data line moved while flag set");
    a_start_done: assert property (start_age_reg != 11'h000 |->
        (done_flag_out ? (start_age_reg >= 11'h384 && bus_state_out == 8'h08)
        : (start_age_reg < 11'h44C)))
        else $error("start did not complete with its status");
    a_stop_silent: assert property (
        clr_wr && ctl_wdata_in[4] && !ctl_wdata_in[5] && done_flag_out
        |=> (!done_flag_out && !irq_out)[*8])
        else $error("flag raised after stop");
    a_scl_hold: assert property (held |-> !scl_oe_n_out)
        else $error("clock line released while flag set");
    a_status_hold: assert property (held |-> $stable(bus_state_out))
        else $error("status changed while flag set");
    c_start: cover property ($rose(done_flag_out) && bus_state_out == 8'h08);
    c_addr_nack: cover property ($rose(done_flag_out) && bus_state_out == 8'h20);
    c_stop: cover property ($fell(busy_out));
endmodule // tws_master_props
`default_nettype wire

/* testbench/tws_slave_model.sv */
// Behavioural slave on the two-wire bus: shifts in bytes, answers in the ninth clock.
// Assumes pulled-up lines resolved by the bench; no clock stretching.
`timescale 1ns/1ps
`default_nettype none
module tws_slave_model #(
    parameter logic [6:0] ADDR = 7'h52
) (
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic nack_data_in,
    output logic sda_oe_n_out,
    output logic [7:0] last_byte_out
);
    int bit_cnt = 0;
    logic first = 0;
    initial sda_oe_n_out = 1'b1;
    initial last_byte_out = 8'h00;
    // Start or repeated start: next byte is the address
    always @(negedge sda_in)
        if (scl_in === 1'b1)
        begin
            bit_cnt = 0;
            first = 1'b1;
        end
    always @(posedge sda_in)
        if (scl_in === 1'b1)
            bit_cnt = 0;
    // MSB first, seven address bits then direction
    always @(posedge scl_in)
    begin
        if (bit_cnt < 8)
            last_byte_out = {last_byte_out[6:0], sda_in};
        bit_cnt++;
    end
    // Acknowledge low in the ninth clock, released after it
    always @(negedge scl_in)
        if (bit_cnt == 8)
        begin
            sda_oe_n_out = first ? (last_byte_out[7:1] != ADDR) : nack_data_in;
            first = 1'b0;
        end
        else if (bit_cnt == 9)
        begin
            sda_oe_n_out = 1'b1;
            bit_cnt = 0;
        end
endmodule // tws_slave_model
`default_nettype wire
